// >>> src/tbcw_pkg.sv
// Purpose: Shared constants and types of the timebase, clock select and watchdog block.
// Assumes: Classic Wishbone slave, 32-bit data, byte addresses, one register per word.
// Notes:   Only event, enable and hold bits 0 and 4 are implemented; the rest read zero.
package tbcw_pkg;

  localparam int unsigned CLOCK_HZ        = 40_000_000;
  localparam int unsigned SUB_OSC_HZ      = 32768;
  localparam int unsigned SLOW_LONG_MS    = 500;
  localparam int unsigned SLOW_SHORT_MS   = 125;
  // Slow prescaler counts that make up each period
  localparam int unsigned SLOW_LONG_TICKS  = SLOW_LONG_MS * SUB_OSC_HZ / 1000;
  localparam int unsigned SLOW_SHORT_TICKS = SLOW_SHORT_MS * SUB_OSC_HZ / 1000;

  localparam int unsigned PRESCALE_WIDTH  = 14;
  localparam int unsigned CLEAR_STAGES    = 4;
  localparam int unsigned DIV128_WIDTH    = 7;
  localparam int unsigned WDOG_WIDTH      = 4;
  localparam int unsigned TAP_SHORT_LOG2  = 11;  // Divide by 2048
  localparam int unsigned TAP_LONG_LOG2   = 14;  // Divide by 16384
  localparam int unsigned SLOW_SHORT_LOG2 = 12;  // 4096 ticks
  localparam int unsigned SLOW_LONG_LOG2  = 14;  // 16384 ticks

  localparam logic [7:0] OFFSET_CLOCK_CONTROL = 8'h00;
  localparam logic [7:0] OFFSET_SUPERVISION   = 8'h04;
  localparam logic [7:0] OFFSET_EVENT_FLAGS   = 8'h08;
  localparam logic [7:0] OFFSET_INT_ENABLE    = 8'h0C;
  localparam logic [7:0] OFFSET_HOLD_ENABLE   = 8'h10;
  localparam logic [7:0] OFFSET_COMMAND       = 8'h14;

  // System clock control fields
  localparam int unsigned CLK_SELECT_SUB_BIT = 0;
  localparam int unsigned CLK_MAIN_OFF_BIT   = 1;
  localparam int unsigned CLK_SLOW_SHORT_BIT = 3;
  localparam logic [3:0]  CLK_WRITE_MASK     = 4'hB;
  // Supervision register fields
  localparam int unsigned SUP_TIMEOUT_BIT    = 0;
  localparam int unsigned SUP_PC_ONLY_BIT    = 1;
  localparam int unsigned SUP_SLOW_TAP_BIT   = 2;
  localparam int unsigned SUP_LONG_TAP_BIT   = 3;
  localparam logic [3:0]  SUP_WRITE_MASK     = 4'hE;
  // Flag registers: fast event in bit 0, slow event in bit 4
  localparam int unsigned FAST_EVENT_BIT     = 0;
  localparam int unsigned SLOW_EVENT_BIT     = 4;
  localparam logic [7:0]  FLAG_MASK          = 8'h11;
  // Command register, write-only pulses
  localparam int unsigned CMD_FAST_CLEAR_BIT = 0;
  localparam int unsigned CMD_SLOW_CLEAR_BIT = 1;
  localparam int unsigned CMD_SUP_CLEAR_BIT  = 2;

  localparam logic [3:0]  CLOCK_CONTROL_RESET = 4'h0;
  localparam logic [3:0]  SUPERVISION_RESET   = 4'h0;
  localparam logic [7:0]  FLAGS_RESET         = 8'h00;

  typedef enum logic {tbcw_running, tbcw_stopped} tbcw_power_type;

  typedef struct packed {
    logic [3:0]                clock_control;
    logic [3:0]                supervision_register;
    logic [7:0]                event_flags;
    logic [7:0]                interrupt_enable_flags;
    logic [7:0]                hold_release_enable_flags;
    logic [PRESCALE_WIDTH-1:0] fast_prescaler;
    logic [PRESCALE_WIDTH-1:0] slow_prescaler;
    logic [DIV128_WIDTH-1:0]   div128;
    logic [WDOG_WIDTH-1:0]     supervision_counter;
    tbcw_power_type            power;
  } tbcw_state_type;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } tbcw_wb_request_type;

  typedef struct packed {
    logic        full_reset;
    logic        pc_reload;
  } tbcw_reset_request_type;

endpackage

// >>> src/tbcw_timebase_watchdog.sv
// Purpose: Two 14-bit prescalers, system clock source select and a 4-bit watchdog.
// Assumes: sub_osc_tick is a one-cycle pulse per sub oscillator period, synchronous to clock.
// Notes:   Watchdog resets of the rest of the chip leave as one-cycle pulses.
//
// Our own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/100ps
module tbcw_timebase_watchdog (
  input  wire logic                            clock,
  input  wire logic                            reset_n,
  input  wire tbcw_pkg::tbcw_wb_request_type   wb_request,
  output logic [31:0]                          wb_dat_o,
  output logic                                 wb_ack_o,
  input  wire logic                            dual_clock_option,
  input  wire logic                            watchdog_option,
  input  wire logic                            sub_osc_tick,
  input  wire logic                            stop_op,
  input  wire logic                            stop_wake,
  output logic                                 main_osc_enable,
  output logic                                 sub_osc_enable,
  output logic                                 system_clock_select_sub,
  output logic                                 display_clock_tick,
  output logic [1:0]                           interrupt_request,
  output logic                                 hold_release,
  output tbcw_pkg::tbcw_reset_request_type     watchdog_reset
);
  import tbcw_pkg::*;

  // Carry out of the low n stages when the counter is about to advance
  function automatic logic stages_full(input logic [PRESCALE_WIDTH-1:0] value,
                                       input int unsigned               n);
    logic [PRESCALE_WIDTH:0] mask;
    mask = (PRESCALE_WIDTH+1)'((64'h1 << n) - 64'h1);
    return &({1'b1, value} | ~mask);
  endfunction

  function automatic logic [PRESCALE_WIDTH-1:0] clear_top(input logic [PRESCALE_WIDTH-1:0] value);
    logic [PRESCALE_WIDTH-1:0] result;
    result = value;
    result[PRESCALE_WIDTH-1 -: CLEAR_STAGES] = '0;
    return result;
  endfunction

  // One bit of the command word, live only on a write strobe to the command offset
  function automatic logic command_bit(input tbcw_wb_request_type request,
                                       input logic                strobe,
                                       input int unsigned         index);
    logic hit;
    hit = strobe & (request.adr == OFFSET_COMMAND);
    return hit & request.dat[index];
  endfunction

  tbcw_state_type         state;
  tbcw_state_type         next_state;
  logic [31:0]            next_wb_dat_o;
  logic                   next_wb_ack_o;
  logic                   next_display_clock_tick;
  tbcw_reset_request_type next_watchdog_reset;

  logic                   access;
  logic                   write_strobe;
  logic                   main_running;
  logic                   slow_tick;
  logic                   fast_event;
  logic                   slow_event;
  logic                   tap_source_tick;
  logic                   watchdog_tick;
  logic                   watchdog_timeout;
  logic                   cmd_fast_clear;
  logic                   cmd_slow_clear;
  logic                   cmd_sup_clear;
  logic [PRESCALE_WIDTH-1:0] tap_value;
  logic [7:0]             flag_sets;

  // Register bus: answer one cycle after the request, drop ack the cycle after
  assign access       = wb_request.cyc & wb_request.stb & ~wb_ack_o;
  assign write_strobe = access & wb_request.we & wb_request.sel[0];

  always_comb begin
    // Main oscillator halts in stop mode, and in dual mode when software turns it off
    main_running = (state.power == tbcw_running)
                 & ~(dual_clock_option & state.clock_control[CLK_MAIN_OFF_BIT]);

    // Slow source: sub oscillator ticks in dual mode, clock/128 otherwise
    slow_tick = dual_clock_option ? (sub_osc_tick & (state.power == tbcw_running))
                                  : (main_running & (&state.div128));

    fast_event = main_running & stages_full(state.fast_prescaler, PRESCALE_WIDTH);
    slow_event = slow_tick & (state.clock_control[CLK_SLOW_SHORT_BIT]
                              ? stages_full(state.slow_prescaler, SLOW_SHORT_LOG2)
                              : stages_full(state.slow_prescaler, SLOW_LONG_LOG2));

    // Watchdog tap follows the chosen prescaler and divide ratio
    tap_value       = state.supervision_register[SUP_SLOW_TAP_BIT] ? state.slow_prescaler
                                                                   : state.fast_prescaler;
    tap_source_tick = state.supervision_register[SUP_SLOW_TAP_BIT] ? slow_tick : main_running;
    watchdog_tick   = watchdog_option & tap_source_tick
                    & (state.supervision_register[SUP_LONG_TAP_BIT]
                       ? stages_full(tap_value, TAP_LONG_LOG2)
                       : stages_full(tap_value, TAP_SHORT_LOG2));
    watchdog_timeout = watchdog_tick & (&state.supervision_counter);

    // Command bits are pulses: nothing is stored, so a later strobe cannot repeat them
    cmd_fast_clear = command_bit(wb_request, write_strobe, CMD_FAST_CLEAR_BIT);
    cmd_slow_clear = command_bit(wb_request, write_strobe, CMD_SLOW_CLEAR_BIT);
    cmd_sup_clear  = command_bit(wb_request, write_strobe, CMD_SUP_CLEAR_BIT);

    flag_sets = '0;
    flag_sets[FAST_EVENT_BIT] = fast_event;
    flag_sets[SLOW_EVENT_BIT] = slow_event;
  end

  always_comb begin
    next_state = state;

    // Power mode: the core's stop instruction enters, a wake event leaves
    case (state.power)
      tbcw_running: begin
        if (stop_op) begin
          next_state.power = tbcw_stopped;
        end
      end
      tbcw_stopped: begin
        if (stop_wake) begin
          next_state.power = tbcw_running;
        end
      end
      default: begin
        next_state.power = tbcw_running;
      end
    endcase

    // Prescalers
    if (main_running) begin
      next_state.fast_prescaler = state.fast_prescaler + 1'b1;
      next_state.div128         = state.div128 + 1'b1;
    end
    if (cmd_fast_clear) begin
      next_state.fast_prescaler = clear_top(next_state.fast_prescaler);
    end
    if (slow_tick) begin
      next_state.slow_prescaler = state.slow_prescaler + 1'b1;
    end
    if (cmd_slow_clear) begin
      next_state.slow_prescaler = clear_top(next_state.slow_prescaler);
    end

    // Software writes
    if (write_strobe) begin
      case (wb_request.adr)
        OFFSET_CLOCK_CONTROL: begin
          // Any value of bits 0, 1 and 3 is taken as written; keeping to a safe switching order is up to software
          next_state.clock_control = wb_request.dat[3:0] & CLK_WRITE_MASK;
        end
        OFFSET_SUPERVISION: begin
          next_state.supervision_register = (wb_request.dat[3:0] & SUP_WRITE_MASK)
                                          | (state.supervision_register & ~SUP_WRITE_MASK);
        end
        OFFSET_EVENT_FLAGS: begin
          // Write one to clear
          next_state.event_flags = state.event_flags & ~(wb_request.dat[7:0] & FLAG_MASK);
        end
        OFFSET_INT_ENABLE: begin
          next_state.interrupt_enable_flags = wb_request.dat[7:0] & FLAG_MASK;
        end
        OFFSET_HOLD_ENABLE: begin
          next_state.hold_release_enable_flags = wb_request.dat[7:0] & FLAG_MASK;
        end
        default: begin
        end
      endcase
    end

    // New events win over a clear in the same cycle
    next_state.event_flags = next_state.event_flags | flag_sets;

    // Watchdog counter
    if (watchdog_tick) begin
      next_state.supervision_counter = state.supervision_counter + 1'b1;
    end
    if (cmd_sup_clear) begin
      next_state.supervision_counter = '0;
      next_state.supervision_register[SUP_TIMEOUT_BIT] = 1'b0;
    end

    if (watchdog_timeout) begin
      next_state.interrupt_enable_flags = FLAGS_RESET;
      if (!state.supervision_register[SUP_PC_ONLY_BIT]) begin
        // Full reset of the timebase state; the tap returns to divide by 2048
        next_state.clock_control             = CLOCK_CONTROL_RESET;
        next_state.event_flags               = FLAGS_RESET;
        next_state.hold_release_enable_flags = FLAGS_RESET;
        next_state.fast_prescaler            = '0;
        next_state.slow_prescaler            = '0;
        next_state.div128                    = '0;
        next_state.supervision_counter       = '0;
        next_state.supervision_register[SUP_LONG_TAP_BIT] = 1'b0;
      end
      // Timeout flag survives the watchdog's own reset and wins over a clear
      next_state.supervision_register[SUP_TIMEOUT_BIT] = 1'b1;
    end

  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state.clock_control             <= CLOCK_CONTROL_RESET;
      state.supervision_register      <= SUPERVISION_RESET;
      state.event_flags               <= FLAGS_RESET;
      state.interrupt_enable_flags    <= FLAGS_RESET;
      state.hold_release_enable_flags <= FLAGS_RESET;
      state.fast_prescaler            <= '0;
      state.slow_prescaler            <= '0;
      state.div128                    <= '0;
      state.supervision_counter       <= '0;
      state.power                     <= tbcw_running;
    end else begin
      state <= next_state;
    end
  end

  // Outgoing pulses are registered so the rest of the chip sees clean one-cycle strobes,
  // at the cost of one cycle of latency behind the event that causes them
  always_comb begin
    next_watchdog_reset.full_reset = watchdog_timeout
                                   & ~state.supervision_register[SUP_PC_ONLY_BIT];

    next_watchdog_reset.pc_reload  = watchdog_timeout;

    next_display_clock_tick        = slow_tick;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      display_clock_tick <= 1'b0;
      watchdog_reset     <= '0;
    end else begin
      display_clock_tick <= next_display_clock_tick;
      watchdog_reset     <= next_watchdog_reset;
    end
  end

  // Register bus answer: always one wait-free cycle; read data stands only with ack,
  // so a master that samples late sees zero rather than stale data
  always_comb begin
    next_wb_ack_o = access;

    next_wb_dat_o = '0;

    if (access && !wb_request.we) begin
      case (wb_request.adr)
        OFFSET_CLOCK_CONTROL: begin
          next_wb_dat_o[3:0] = state.clock_control;
        end
        OFFSET_SUPERVISION: begin
          next_wb_dat_o[3:0] = state.supervision_register;
        end
        OFFSET_EVENT_FLAGS: begin
          next_wb_dat_o[7:0] = state.event_flags;
        end
        OFFSET_INT_ENABLE: begin
          next_wb_dat_o[7:0] = state.interrupt_enable_flags;
        end
        OFFSET_HOLD_ENABLE: begin
          next_wb_dat_o[7:0] = state.hold_release_enable_flags;
        end
        default: begin
          // Unmapped offsets and the write-only command word read zero
          next_wb_dat_o = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wb_dat_o <= '0;
      wb_ack_o <= 1'b0;
    end else begin
      wb_dat_o <= next_wb_dat_o;
      wb_ack_o <= next_wb_ack_o;
    end
  end

  // Oscillator controls and status levels are gates on registered state, plus dual_clock_option for the enables,
  // so no bus or stop input reaches them without a register in between

  assign main_osc_enable         = main_running;
  assign sub_osc_enable          = dual_clock_option & (state.power == tbcw_running);
  assign system_clock_select_sub = state.clock_control[CLK_SELECT_SUB_BIT];
  assign interrupt_request[0]    = state.event_flags[FAST_EVENT_BIT]
                                 & state.interrupt_enable_flags[FAST_EVENT_BIT];
  assign interrupt_request[1]    = state.event_flags[SLOW_EVENT_BIT]
                                 & state.interrupt_enable_flags[SLOW_EVENT_BIT];
  assign hold_release            = |(state.event_flags & state.hold_release_enable_flags);

endmodule // tbcw_timebase_watchdog

// >>> bench/tbcw_timebase_watchdog_asserts.sv
// Purpose: Port-level assertions for the timebase, clock select and watchdog block.
// Assumes: One clock domain; reset_n asynchronous, active low.
// Notes:   Bound to the design from the testbench top file.
`timescale 1ns/100ps
module tbcw_checker (
  input wire logic                            clock,
  input wire logic                            reset_n,
  input wire tbcw_pkg::tbcw_wb_request_type   wb_request,
  input wire logic [31:0]                     wb_dat_o,
  input wire logic                            wb_ack_o,
  input wire logic                            dual_clock_option,
  input wire logic                            watchdog_option,
  input wire logic                            sub_osc_tick,
  input wire logic                            stop_op,
  input wire logic                            stop_wake,
  input wire logic                            main_osc_enable,
  input wire logic                            sub_osc_enable,
  input wire logic                            system_clock_select_sub,
  input wire logic                            display_clock_tick,
  input wire logic [1:0]                      interrupt_request,
  input wire logic                            hold_release,
  input wire tbcw_pkg::tbcw_reset_request_type watchdog_reset
);
  import tbcw_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence s_take; wb_request.cyc && wb_request.stb && !wb_ack_o; endsequence
  sequence s_ctl_write; s_take ##0 (wb_request.we && wb_request.sel[0] && wb_request.adr == OFFSET_CLOCK_CONTROL);
  endsequence
  property p_ack_answer; s_take |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("ack not a single pulse after request");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data not zero outside ack");
  property p_src_select; s_ctl_write |=> system_clock_select_sub == $past(wb_request.dat[0]); endproperty
  a_src_select: assert property (p_src_select) else $error("clock source not taken from write");
  property p_main_off; s_ctl_write ##0 (dual_clock_option && sub_osc_enable && !stop_op)
    |=> main_osc_enable == !$past(wb_request.dat[1]); endproperty
  a_main_off: assert property (p_main_off) else $error("main oscillator enable wrong");
  property p_stop_sub; stop_op && !stop_wake |=> !sub_osc_enable && !main_osc_enable; endproperty
  a_stop_sub: assert property (p_stop_sub) else $error("oscillators run in stop");
  property p_dual_display; dual_clock_option && sub_osc_tick && sub_osc_enable |=> display_clock_tick; endproperty
  a_dual_display: assert property (p_dual_display) else $error("display tick missing for sub tick");
  property p_single_display; display_clock_tick && !dual_clock_option
    |-> ##128 (display_clock_tick || dual_clock_option || !main_osc_enable); endproperty
  a_single_display: assert property (p_single_display) else $error("display tick not every 128 clocks");
  property p_wd_full_pc; watchdog_reset.full_reset |-> watchdog_reset.pc_reload; endproperty
  a_wd_full_pc: assert property (p_wd_full_pc) else $error("full reset without pc reload");
  property p_wd_off; !watchdog_option && !$past(watchdog_option) && !$past(watchdog_option, 2)
    |-> !watchdog_reset.pc_reload; endproperty
  a_wd_off: assert property (p_wd_off) else $error("watchdog fired while disabled");
  property p_wd_pc_clears; watchdog_reset.pc_reload |=> interrupt_request == 2'h0; endproperty
  a_wd_pc_clears: assert property (p_wd_pc_clears) else $error("interrupts still enabled after timeout");
  property p_wd_full_clears; watchdog_reset.full_reset |=> !system_clock_select_sub && !hold_release;
  endproperty
  a_wd_full_clears: assert property (p_wd_full_clears) else $error("state kept after full reset");
endmodule // tbcw_checker

// >>> bench/tb_tbcw_timebase_watchdog.sv
// Purpose: Self-checking bench for the timebase, clock select and watchdog block.
// Assumes: Sub oscillator ticks every other clock once started.
// Notes:   Slow prescaler test runs inside the first watchdog window to save time.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb_tbcw_timebase_watchdog;
  import tbcw_pkg::*;
  typedef struct {logic [7:0] adr; logic [31:0] wd; logic [31:0] rd; logic sel;} tbcw_row_type;
  logic                   clock = 1'b0;
  logic                   reset_n = 1'b0;
  tbcw_wb_request_type    wb_request = '0;
  logic [31:0]            wb_dat_o;
  logic                   wb_ack_o;
  logic                   dual_clock_option = 1'b0;
  logic                   watchdog_option = 1'b0;
  logic                   sub_osc_tick = 1'b0;
  logic                   stop_op = 1'b0;
  logic                   stop_wake = 1'b0;
  logic                   main_osc_enable, sub_osc_enable, system_clock_select_sub, display_clock_tick, hold_release;
  logic [1:0]             interrupt_request;
  tbcw_reset_request_type watchdog_reset;
  logic                   tick_run = 1'b0;
  logic [31:0]            rdata;
  int                     mismatches = 0;
  int                     n_tests = 0;
  int                     cycles = 0;
  int                     t0;
  int                     tw;
  tbcw_row_type rows [8] = '{'{8'h00, 32'hF, 32'hB, 1'b1}, '{8'h00, 32'h0, 32'h0, 1'b0},
    '{8'h04, 32'hF, 32'hE, 1'b0}, '{8'h04, 32'h0, 32'h0, 1'b0}, '{8'h0C, 32'hFF, 32'h11, 1'b0},
    '{8'h10, 32'hFF, 32'h11, 1'b0}, '{8'h14, 32'h7, 32'h0, 1'b0}, '{8'h3C, 32'hFF, 32'h0, 1'b0}};

  tbcw_timebase_watchdog u_tbcw_timebase_watchdog (.*);

  always #12.5 clock = ~clock;
  always @(posedge clock) cycles <= cycles + 1;
  always @(posedge clock) sub_osc_tick <= tick_run & ~sub_osc_tick;

  task automatic end_of_test();
    if (mismatches == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Leaves one idle edge before each request so cyc and stb drop between cycles
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clock);
    wb_request <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: wd};
    @(posedge clock);
    while (wb_ack_o !== 1'b1) begin
      n++;
      if (n > 16) begin mismatches++; end_of_test(); end
      @(posedge clock);
    end
    rdata = wb_dat_o;
    wb_request <= '0;
  endtask

  task automatic rchk(input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0);
    `CHK("read data", exp, rdata)
  endtask

  task automatic wait_for(input int which, input int limit);
    int n;
    n = 0;
    while ((which == 2 ? watchdog_reset.pc_reload : interrupt_request[which]) !== 1'b1) begin
      n++;
      if (n > limit) begin mismatches++; end_of_test(); end
      @(posedge clock);
    end
  endtask

  initial begin
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    rchk(OFFSET_SUPERVISION, 32'h0);
    rchk(OFFSET_CLOCK_CONTROL, 32'h0);
    foreach (rows[i]) begin
      wb(1'b1, rows[i].adr, rows[i].wd);
      rchk(rows[i].adr, rows[i].rd);
      `CHK("clock select", rows[i].sel, system_clock_select_sub)
      `CHK("main enable", 1'b1, main_osc_enable)
    end
    wb(1'b1, OFFSET_EVENT_FLAGS, 32'h11);
    wait_for(0, 20000);
    t0 = cycles;
    `CHK("hold release", 1'b1, hold_release)
    rchk(OFFSET_EVENT_FLAGS, 32'h01);
    wb(1'b1, OFFSET_EVENT_FLAGS, 32'h01);
    // Clear lands about 5000 clocks in, dropping four whole 1024-clock stages
    repeat (5000) @(posedge clock);
    wb(1'b1, OFFSET_COMMAND, 32'h1);
    wait_for(0, 25000);
    `CHK("fast period", 20480, cycles - t0)
    wb(1'b1, OFFSET_SUPERVISION, 32'h2);
    wb(1'b1, OFFSET_COMMAND, 32'h4);
    watchdog_option <= 1'b1;
    tw = cycles;
    dual_clock_option <= 1'b1;
    tick_run <= 1'b1;
    wb(1'b1, OFFSET_CLOCK_CONTROL, 32'h8);
    wb(1'b1, OFFSET_EVENT_FLAGS, 32'h11);
    wait_for(1, 9000);
    t0 = cycles;
    wb(1'b1, OFFSET_EVENT_FLAGS, 32'h10);
    wait_for(1, 9000);
    `CHK("slow period", 8192, cycles - t0)
    wait_for(2, 33000);
    `CHK("watchdog period", 1'b1, (cycles - tw >= 30720) && (cycles - tw <= 32776))
    `CHK("full reset", 1'b0, watchdog_reset.full_reset)
    rchk(OFFSET_SUPERVISION, 32'h3);
    rchk(OFFSET_INT_ENABLE, 32'h0);
    wb(1'b1, OFFSET_CLOCK_CONTROL, 32'h1);
    wb(1'b1, OFFSET_CLOCK_CONTROL, 32'h3);
    `CHK("main enable", 1'b0, main_osc_enable)
    `CHK("clock select", 1'b1, system_clock_select_sub)
    wb(1'b1, OFFSET_CLOCK_CONTROL, 32'h1);
    repeat (32) @(posedge clock);
    wb(1'b1, OFFSET_CLOCK_CONTROL, 32'h0);
    stop_op <= 1'b1;
    @(posedge clock);
    stop_op <= 1'b0;
    @(posedge clock);
    `CHK("sub enable", 1'b0, sub_osc_enable)
    stop_wake <= 1'b1;
    @(posedge clock);
    stop_wake <= 1'b0;
    @(posedge clock);
    `CHK("sub enable", 1'b1, sub_osc_enable)
    wb(1'b1, OFFSET_SUPERVISION, 32'h0);
    wb(1'b1, OFFSET_CLOCK_CONTROL, 32'h8);
    wb(1'b1, OFFSET_COMMAND, 32'h4);
    rchk(OFFSET_SUPERVISION, 32'h0);
    wait_for(2, 33000);
    `CHK("full reset", 1'b1, watchdog_reset.full_reset)
    rchk(OFFSET_CLOCK_CONTROL, 32'h0);
    rchk(OFFSET_SUPERVISION, 32'h1);
    watchdog_option <= 1'b0;
    end_of_test();
  end
endmodule // tb_tbcw_timebase_watchdog

bind tbcw_timebase_watchdog tbcw_checker u_tbcw_checker (.*);
